// File: ets_pkg.sv
// Purpose: Shared constants for the 256-bit transmit stream between client logic and the MAC end.
// Assumes: One stream clock; both ends compile against this package.
// Notes: Entry layout describes one word held in the transmit buffer of the MAC end.
package ets_pkg;

   // -------------------------------------------------------------------------
   // Stream geometry
   // -------------------------------------------------------------------------
   localparam int DATA_W = 256;
   localparam int LANE_W = 8;
   localparam int KEEP_W = DATA_W / LANE_W;
   localparam int FIFO_DEPTH = 8;
   localparam int LEN_W = 16;

   // -------------------------------------------------------------------------
   // Clocking
   // -------------------------------------------------------------------------
   // Nominal stream clock for 40 Gb/s operation, in kHz.
   localparam int STREAM_CLK_40G_KHZ = 312500;
   localparam int SYNC_STAGES = 2;

   // -------------------------------------------------------------------------
   // Line coding
   // -------------------------------------------------------------------------
   // Control code that marks an errored byte on the line side.
   localparam logic [LANE_W-1:0] ERR_CTRL_CODE = 8'hFE;
   localparam logic [KEEP_W-1:0] KEEP_ALL = 32'hFFFFFFFF;
   localparam logic [KEEP_W-1:0] KEEP_NONE = 32'h00000000;

   // -------------------------------------------------------------------------
   // Buffer entry layout: {abort, err, last, keep, data}
   // -------------------------------------------------------------------------
   localparam int ENT_DATA_LSB = 0;
   localparam int ENT_KEEP_LSB = DATA_W;
   localparam int ENT_LAST = DATA_W + KEEP_W;
   localparam int ENT_ERR = ENT_LAST + 1;
   localparam int ENT_ABORT = ENT_ERR + 1;
   localparam int ENT_W = ENT_ABORT + 1;

   // Run of ones from lane 0 covering the given number of bytes.
   function automatic logic [KEEP_W-1:0] keep_mask(input logic [LEN_W-1:0] nbytes);
      logic [KEEP_W-1:0] m;
      m = KEEP_NONE;
      for (int i = 0; i < KEEP_W; i++) begin
         if (LEN_W'(i) < nbytes) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

endpackage

// File: ets_axis_if.sv
// Purpose: Transmit stream carrier joining the client end and the MAC end.
// Assumes: All signals change and are sampled on the rising edge of clk.
// Notes: One modport per party; no clocking block.
`timescale 1ns/100ps
`default_nettype none
interface ets_axis_if (
   input wire logic clk
);
   logic tvalid;
   logic tready;
   logic [ets_pkg::DATA_W-1:0] tdata;
   logic [ets_pkg::KEEP_W-1:0] tkeep;
   logic tlast;
   logic tuser;

   modport mac (
      input tvalid,
      input tdata,
      input tkeep,
      input tlast,
      input tuser,
      output tready
   );

   modport client (
      output tvalid,
      output tdata,
      output tkeep,
      output tlast,
      output tuser,
      input tready
   );
endinterface
`default_nettype wire

// File: ets_mac_tx.sv
// Purpose: MAC end of the 256-bit transmit stream with an 8-word buffer and line-side output stage.
// Assumes: REF_CLK_I is the stream clock; NRST_I is the asynchronous power-on reset.
// Notes: TX and RX resets are synchronous requests and are resynchronised before use.
//
// Summary of operation
// R1: 256-bit stream path for 40 Gb/s operation.
// R2: All exchange on rising stream clock edge.
// R3: Client holds resets high until clock stable.
// R4: Resets synchronous, resynchronised into clock domain.
// R5: 32 byte lanes, keep bit n qualifies lane.
// R6: User bit one means bad packet.
// R7: Client raises valid with data and keep.
// R8: After acceptance client presents next word.
// R9: Client holds word while ready low.
// R10: Last marks final word, keep gives count.
// R11: Bus ignored after last until valid returns.
// R12: Back-to-back frames split only by last.
// R13: Ready may drop anytime to throttle.
// R14: Valid word stays stable until accepted.
// R15: User bit with last means explicit abort.
// R16: Valid dropped before last means implicit abort.
// R17: Bad frame gets error code, skips FCS.
// R18: Stream clock nominally 312.5 MHz at 40G.
// R19: Keep all ones except final transfer.
// R20: Final keep is run from lane 0.
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// MAC transmit end
// ----------------------------------------------------------------------------
module ets_mac_tx #(
   parameter int FIFO_DEPTH = ets_pkg::FIFO_DEPTH
) (
   // Stream clock and power-on reset
   input wire logic REF_CLK_I,
   input wire logic NRST_I,
   // Synchronous reset requests, active high
   input wire logic TX_RESET_I,
   input wire logic RX_RESET_I,
   // Client stream
   ets_axis_if.mac S,
   // Line side
   output logic LINE_VALID_O,
   input wire logic LINE_READY_I,
   output logic [ets_pkg::DATA_W-1:0] LINE_DATA_O,
   output logic [ets_pkg::KEEP_W-1:0] LINE_KEEP_O,
   output logic LINE_LAST_O,
   output logic LINE_ERR_O,
   output logic LINE_ABORT_O,
   output logic LINE_FCS_SKIP_O,
   // Status
   output logic TX_RESET_SYNC_O,
   output logic RX_RESET_SYNC_O,
   output logic UNDERRUN_O
);
   // -------------------------------------------------------------------------
   // Reset synchronisers
   // -------------------------------------------------------------------------
   logic [ets_pkg::SYNC_STAGES-1:0] tx_rst_sync;
   logic [ets_pkg::SYNC_STAGES-1:0] rx_rst_sync;
   logic tx_rst;

   // Reset requests pass two flops; power-on holds them asserted. R4 R3
   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         tx_rst_sync <= '1;
         rx_rst_sync <= '1;
      end else begin
         tx_rst_sync <= {tx_rst_sync[ets_pkg::SYNC_STAGES-2:0], TX_RESET_I};
         rx_rst_sync <= {rx_rst_sync[ets_pkg::SYNC_STAGES-2:0], RX_RESET_I};
      end
   end
   assign tx_rst = tx_rst_sync[ets_pkg::SYNC_STAGES-1];

   // -------------------------------------------------------------------------
   // Client side acceptance
   // -------------------------------------------------------------------------
   // Everything here runs on the single stream clock, which is 312.5 MHz in 40G use. R2 R18
   logic in_frame;
   logic abort_pend;
   logic ready;
   logic next_in_frame;
   logic next_abort_pend;
   logic next_ready;
   logic next_underrun;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [ets_pkg::ENT_W-1:0] fifo_in_data;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [ets_pkg::ENT_W-1:0] fifo_out_data;
   logic take;
   logic [$clog2(FIFO_DEPTH+1)-1:0] fill;
   logic [$clog2(FIFO_DEPTH+1)-1:0] next_fill;

   // A word is taken only on valid and ready, so idle bus contents are ignored. R11 R7 R8 R9
   assign take = S.tvalid && ready;

   always_comb begin
      next_in_frame = in_frame;
      next_abort_pend = abort_pend;
      next_underrun = 1'b0;
      fifo_in_valid = 1'b0;
      fifo_in_data = {1'b0, 1'b0, S.tlast, S.tkeep, S.tdata}; // R5 R1
      if (abort_pend) begin
         // Closing entry for a frame that lost its valid mid-way.
         fifo_in_valid = 1'b1;
         fifo_in_data = {1'b1, 1'b1, 1'b1, ets_pkg::KEEP_NONE, {ets_pkg::DATA_W{1'b0}}}; // R16
         if (fifo_in_ready) begin
            next_abort_pend = 1'b0;
         end
      end else if (take) begin
         fifo_in_valid = 1'b1;
         // User bit is sampled with last only: bad or explicit abort. R6 R15
         fifo_in_data[ets_pkg::ENT_ERR] = S.tlast && S.tuser;
         next_in_frame = !S.tlast; // R12
      end else if (in_frame && !S.tvalid) begin
         next_in_frame = 1'b0; // R16
         next_abort_pend = 1'b1;
         next_underrun = 1'b1;
      end
      // Ready is registered, so it stays up only while the buffer keeps a free entry next cycle. R13
      next_ready = !tx_rst && !next_abort_pend && (next_fill != $bits(next_fill)'(FIFO_DEPTH));
   end

   always_comb begin
      next_fill = fill;
      if (tx_rst) begin
         next_fill = '0;
      end else if (fifo_in_valid && fifo_in_ready && !(fifo_out_valid && fifo_out_ready)) begin
         next_fill = fill + 1'b1;
      end else if (!(fifo_in_valid && fifo_in_ready) && fifo_out_valid && fifo_out_ready) begin
         next_fill = fill - 1'b1;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         in_frame <= 1'b0;
         abort_pend <= 1'b0;
         ready <= 1'b0;
         fill <= '0;
         UNDERRUN_O <= 1'b0;
      end else if (tx_rst) begin
         in_frame <= 1'b0;
         abort_pend <= 1'b0;
         ready <= 1'b0;
         fill <= '0;
         UNDERRUN_O <= 1'b0;
      end else begin
         in_frame <= next_in_frame;
         abort_pend <= next_abort_pend;
         ready <= next_ready;
         fill <= next_fill;
         UNDERRUN_O <= next_underrun;
      end
   end
   assign S.tready = ready;

   ets_fifo #(
      .WIDTH(ets_pkg::ENT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(REF_CLK_I),
      .rst_n_i(NRST_I),
      .flush_i(tx_rst),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data)
   );

   // -------------------------------------------------------------------------
   // Line-side output stage
   // -------------------------------------------------------------------------
   logic next_line_valid;
   logic [ets_pkg::DATA_W-1:0] next_line_data;
   logic [ets_pkg::KEEP_W-1:0] next_line_keep;
   logic next_line_last;
   logic next_line_err;
   logic next_line_abort;

   assign fifo_out_ready = !LINE_VALID_O || LINE_READY_I;

   always_comb begin
      next_line_valid = LINE_VALID_O && !LINE_READY_I;
      next_line_data = LINE_DATA_O;
      next_line_keep = LINE_KEEP_O;
      next_line_last = LINE_LAST_O;
      next_line_err = LINE_ERR_O;
      next_line_abort = LINE_ABORT_O;
      if (fifo_out_ready && fifo_out_valid) begin
         next_line_valid = 1'b1;
         next_line_data = fifo_out_data[ets_pkg::ENT_KEEP_LSB-1:ets_pkg::ENT_DATA_LSB];
         next_line_keep = fifo_out_data[ets_pkg::ENT_LAST-1:ets_pkg::ENT_KEEP_LSB];
         next_line_last = fifo_out_data[ets_pkg::ENT_LAST];
         next_line_err = fifo_out_data[ets_pkg::ENT_ERR];
         next_line_abort = fifo_out_data[ets_pkg::ENT_ABORT];
         if (fifo_out_data[ets_pkg::ENT_ERR]) begin
            // Last word of a bad frame becomes error control codes. R17
            next_line_data = {ets_pkg::KEEP_W{ets_pkg::ERR_CTRL_CODE}};
         end
      end
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         LINE_VALID_O <= 1'b0;
         LINE_DATA_O <= '0;
         LINE_KEEP_O <= ets_pkg::KEEP_NONE;
         LINE_LAST_O <= 1'b0;
         LINE_ERR_O <= 1'b0;
         LINE_ABORT_O <= 1'b0;
         LINE_FCS_SKIP_O <= 1'b0;
      end else if (tx_rst) begin
         LINE_VALID_O <= 1'b0;
         LINE_LAST_O <= 1'b0;
         LINE_ERR_O <= 1'b0;
         LINE_ABORT_O <= 1'b0;
         LINE_FCS_SKIP_O <= 1'b0;
      end else begin
         LINE_VALID_O <= next_line_valid;
         LINE_DATA_O <= next_line_data;
         LINE_KEEP_O <= next_line_keep;
         LINE_LAST_O <= next_line_last;
         LINE_ERR_O <= next_line_err;
         LINE_ABORT_O <= next_line_abort;
         LINE_FCS_SKIP_O <= next_line_err; // R17
      end
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         TX_RESET_SYNC_O <= 1'b1;
         RX_RESET_SYNC_O <= 1'b1;
      end else begin
         TX_RESET_SYNC_O <= tx_rst;
         RX_RESET_SYNC_O <= rx_rst_sync[ets_pkg::SYNC_STAGES-1]; // R4
      end
   end
endmodule
`default_nettype wire

// File: ets_client_tx.sv
// Purpose: Client end that turns frame requests into words on the 256-bit transmit stream.
// Assumes: Request inputs come from logic on the same stream clock.
// Notes: Payload bytes are a running count so a receiver can check order; the MAC end's word buffer lives here too.
`timescale 1ns/100ps
`default_nettype none
module ets_client_tx (
   // Stream clock and reset
   input wire logic REF_CLK_I,
   input wire logic NRST_I,
   // Stream to the MAC end
   ets_axis_if.client M,
   // Frame requests
   input wire logic FRAME_START_I,
   input wire logic [ets_pkg::LEN_W-1:0] FRAME_LEN_I,
   input wire logic FRAME_BAD_I,
   input wire logic FRAME_ABORT_I,
   // Status
   output logic BUSY_O,
   output logic DONE_O
);
   typedef enum logic [0:0] {ETS_IDLE, ETS_SEND} ets_cstate_t;

   ets_cstate_t state;
   ets_cstate_t next_state;
   logic [ets_pkg::LEN_W-1:0] remain;
   logic [ets_pkg::LEN_W-1:0] next_remain;
   logic [ets_pkg::LANE_W-1:0] seq;
   logic [ets_pkg::LANE_W-1:0] next_seq;
   logic bad;
   logic next_bad;
   logic tvalid;
   logic next_tvalid;
   logic [ets_pkg::DATA_W-1:0] tdata;
   logic [ets_pkg::DATA_W-1:0] next_tdata;
   logic [ets_pkg::KEEP_W-1:0] tkeep;
   logic [ets_pkg::KEEP_W-1:0] next_tkeep;
   logic tlast;
   logic next_tlast;
   logic tuser;
   logic next_tuser;
   logic next_done;
   logic advance;

   // A new word is loaded only once the current one is taken. R9 R14 R8
   assign advance = !tvalid || M.tready;

   always_comb begin
      next_state = state;
      next_remain = remain;
      next_seq = seq;
      next_bad = bad;
      next_tvalid = tvalid;
      next_tdata = tdata;
      next_tkeep = tkeep;
      next_tlast = tlast;
      next_tuser = tuser;
      next_done = 1'b0;
      unique case (state)
         ETS_IDLE: begin
            if (M.tready) begin
               next_tvalid = 1'b0;
               next_tlast = 1'b0;
            end
            if (FRAME_START_I && FRAME_LEN_I != '0 && advance) begin
               next_state = ETS_SEND;
               next_remain = FRAME_LEN_I;
               next_bad = FRAME_BAD_I;
            end
         end
         ETS_SEND: begin
            if (advance && FRAME_ABORT_I && tvalid) begin
               // Dropping valid before last aborts the frame. R16
               next_tvalid = 1'b0;
               next_tlast = 1'b0;
               next_state = ETS_IDLE;
               next_done = 1'b1;
            end else if (advance) begin
               // Valid, data and keep rise together. R7
               next_tvalid = 1'b1;
               for (int i = 0; i < ets_pkg::KEEP_W; i++) begin
                  next_tdata[i*ets_pkg::LANE_W +: ets_pkg::LANE_W] = seq + ets_pkg::LANE_W'(i); // R5
               end
               next_seq = seq + ets_pkg::LANE_W'(ets_pkg::KEEP_W);
               if (remain <= ets_pkg::LEN_W'(ets_pkg::KEEP_W)) begin
                  next_tkeep = ets_pkg::keep_mask(remain); // R20 R10
                  next_tlast = 1'b1; // R10
                  next_tuser = bad; // R6 R15
                  next_remain = '0;
                  next_state = ETS_IDLE;
                  next_done = 1'b1;
               end else begin
                  next_tkeep = ets_pkg::KEEP_ALL; // R19
                  next_tlast = 1'b0;
                  next_tuser = 1'b0;
                  next_remain = remain - ets_pkg::LEN_W'(ets_pkg::KEEP_W);
               end
            end
         end
      endcase
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin // R2
      if (!NRST_I) begin
         state <= ETS_IDLE;
         remain <= '0;
         seq <= '0;
         bad <= 1'b0;
         tvalid <= 1'b0;
         tdata <= '0;
         tkeep <= ets_pkg::KEEP_NONE;
         tlast <= 1'b0;
         tuser <= 1'b0;
         DONE_O <= 1'b0;
         BUSY_O <= 1'b0;
      end else begin
         state <= next_state;
         remain <= next_remain;
         seq <= next_seq;
         bad <= next_bad;
         tvalid <= next_tvalid;
         tdata <= next_tdata;
         tkeep <= next_tkeep;
         tlast <= next_tlast;
         tuser <= next_tuser;
         DONE_O <= next_done;
         BUSY_O <= (next_state == ETS_SEND) || next_tvalid;
      end
   end

   assign M.tvalid = tvalid;
   assign M.tdata = tdata;
   assign M.tkeep = tkeep;
   assign M.tlast = tlast;
   assign M.tuser = tuser;
endmodule

// ----------------------------------------------------------------------------
// Word buffer
// ----------------------------------------------------------------------------
module ets_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic flush_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] count;
   logic [PTR_W-1:0] next_wr_ptr;
   logic [PTR_W-1:0] next_rd_ptr;
   logic [CNT_W-1:0] next_count;
   logic push;
   logic pop;

   assign in_ready_o = (count != CNT_W'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (flush_i) begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count = '0;
      end else begin
         if (push) begin
            next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            next_count = count + 1'b1;
         end else if (pop && !push) begin
            next_count = count - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // Storage has no reset; only pointers and count carry meaning.
   always_ff @(posedge clk_i) begin
      if (push && !flush_i) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule
`default_nettype wire

// File: ets_stream_properties.sv
// Purpose: Concurrent checks on the transmit stream carrier between the two ends.
// Assumes: Every signal is sampled on the rising edge of clk; NRST_I is active low.
// Notes: Only the carrier is watched, so both ends are judged together.
`timescale 1ns/100ps
`default_nettype none
module ets_stream_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic NRST_I,
   // Carrier
   input wire logic tvalid,
   input wire logic tready,
   input wire logic [ets_pkg::DATA_W-1:0] tdata,
   input wire logic [ets_pkg::KEEP_W-1:0] tkeep,
   input wire logic tlast,
   input wire logic tuser
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!NRST_I);

   // -------------------------------------------------------------------------
   // Handshake
   // -------------------------------------------------------------------------
   chk_hold_while_stalled: assert property (tvalid && !tready |=> tvalid && $stable(tdata) && $stable(tkeep)
      && $stable(tlast) && $stable(tuser)) else $error("word changed while stalled");
   chk_last_single_cycle: assert property (tvalid && tready && tlast |=> !(tvalid && tlast))
      else $error("last held past its transfer");
   chk_reset_idle_bus: assert property ($rose(NRST_I) |-> !tvalid && !tready)
      else $error("bus not idle after reset");
   chk_ready_held_low: assert property ($rose(NRST_I) |-> !tready ##1 !tready)
      else $error("ready rose before reset sync");

   // -------------------------------------------------------------------------
   // Word contents
   // -------------------------------------------------------------------------
   chk_keep_full_word: assert property (tvalid && !tlast |-> tkeep == ets_pkg::KEEP_ALL)
      else $error("partial keep before last");
   chk_keep_run_lane0: assert property (tvalid && tlast |-> tkeep[0]
      && ((tkeep + 32'h00000001) & tkeep) == 32'h00000000)
      else $error("final keep not a run from lane 0");
   chk_user_only_last: assert property (tvalid && !tlast |-> !tuser)
      else $error("bad flag outside last transfer");
   chk_lane_low_order: assert property (tvalid && tkeep[1] |-> tdata[15:8] == tdata[7:0] + 8'h01)
      else $error("lane 1 out of order");
   chk_lane_top_order: assert property (tvalid && tkeep[31] |-> tdata[255:248] == tdata[247:240] + 8'h01)
      else $error("lane 31 out of order");

   cover property (tvalid && tready && tlast && tuser);
   cover property (tvalid && !tready);
   cover property ($fell(tvalid) && !$past(tlast));
endmodule
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench joining the client end and the MAC end over the stream carrier.
// Assumes: Inputs change on the falling clock edge; line words are captured when taken.
// Notes: Byte values are checked relative to the first byte, since the running count start is free.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic REF_CLK_I = 1'b0;
   logic NRST_I = 1'b0;
   logic TX_RESET_I = 1'b1;
   logic RX_RESET_I = 1'b1;
   logic LINE_READY_I = 1'b1;
   logic FRAME_START_I = 1'b0;
   logic [ets_pkg::LEN_W-1:0] FRAME_LEN_I = 16'h0000;
   logic FRAME_BAD_I = 1'b0;
   logic FRAME_ABORT_I = 1'b0;
   logic LINE_VALID_O, LINE_LAST_O, LINE_ERR_O, LINE_ABORT_O, LINE_FCS_SKIP_O;
   logic TX_RESET_SYNC_O, RX_RESET_SYNC_O, UNDERRUN_O, BUSY_O, DONE_O;
   logic [ets_pkg::DATA_W-1:0] LINE_DATA_O;
   logic [ets_pkg::KEEP_W-1:0] LINE_KEEP_O;
   logic [ets_pkg::DATA_W-1:0] q_data[$];
   logic [ets_pkg::KEEP_W-1:0] q_keep[$];
   logic [3:0] q_flag[$];
   logic [ets_pkg::LEN_W-1:0] lens [6] = '{16'h0001, 16'h0020, 16'h0021, 16'h0040, 16'h005F, 16'h0100};
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   int underruns = 0;
   int dones = 0;
   int stalls = 0;

   ets_axis_if ets_axis_if_inst (.clk(REF_CLK_I));
   ets_client_tx ets_client_tx_inst (.REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .M(ets_axis_if_inst),
      .FRAME_START_I(FRAME_START_I), .FRAME_LEN_I(FRAME_LEN_I), .FRAME_BAD_I(FRAME_BAD_I),
      .FRAME_ABORT_I(FRAME_ABORT_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O));
   ets_mac_tx ets_mac_tx_inst (.REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .TX_RESET_I(TX_RESET_I),
      .RX_RESET_I(RX_RESET_I), .S(ets_axis_if_inst), .LINE_VALID_O(LINE_VALID_O), .LINE_READY_I(LINE_READY_I),
      .LINE_DATA_O(LINE_DATA_O), .LINE_KEEP_O(LINE_KEEP_O), .LINE_LAST_O(LINE_LAST_O), .LINE_ERR_O(LINE_ERR_O),
      .LINE_ABORT_O(LINE_ABORT_O), .LINE_FCS_SKIP_O(LINE_FCS_SKIP_O), .TX_RESET_SYNC_O(TX_RESET_SYNC_O),
      .RX_RESET_SYNC_O(RX_RESET_SYNC_O), .UNDERRUN_O(UNDERRUN_O));
   ets_stream_properties ets_stream_properties_inst (.clk(REF_CLK_I), .NRST_I(NRST_I),
      .tvalid(ets_axis_if_inst.tvalid), .tready(ets_axis_if_inst.tready), .tdata(ets_axis_if_inst.tdata),
      .tkeep(ets_axis_if_inst.tkeep), .tlast(ets_axis_if_inst.tlast), .tuser(ets_axis_if_inst.tuser));

   always #50 REF_CLK_I = ~REF_CLK_I;

   // -------------------------------------------------------------------------
   // Line capture and timeout
   // -------------------------------------------------------------------------
   always @(posedge REF_CLK_I) begin
      cycles++;
      if (LINE_VALID_O === 1'b1 && LINE_READY_I) begin
         q_data.push_back(LINE_DATA_O);
         q_keep.push_back(LINE_KEEP_O);
         q_flag.push_back({LINE_LAST_O, LINE_ERR_O, LINE_ABORT_O, LINE_FCS_SKIP_O});
      end
      if (UNDERRUN_O === 1'b1) underruns++;
      if (DONE_O === 1'b1) dones++;
      if (ets_axis_if_inst.tvalid === 1'b1 && ets_axis_if_inst.tready === 1'b0) stalls++;
      if (cycles == 20000) begin
         mismatches++;
         $display("ERROR timeout expected finish seen hang");
         end_of_test();
      end
   end

   task automatic cmp(input string name, input logic [255:0] exp, input logic [255:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Line is held off from start until hold cycles after the abort point; abort is raised abort_at cycles after start drops.
   task automatic run_frame(input logic [15:0] len, input logic bad, input int abort_at, input int hold);
      int k;
      @(negedge REF_CLK_I);
      FRAME_START_I = 1'b1;
      FRAME_LEN_I = len;
      FRAME_BAD_I = bad;
      LINE_READY_I = (hold == 0);
      @(negedge REF_CLK_I);
      FRAME_START_I = 1'b0;
      for (k = 0; k < abort_at; k++) @(negedge REF_CLK_I);
      FRAME_ABORT_I = (abort_at > 0);
      for (k = 0; k < hold; k++) @(negedge REF_CLK_I);
      LINE_READY_I = 1'b1;
      for (k = 0; k < 2000 && BUSY_O !== 1'b0; k++) @(negedge REF_CLK_I);
      FRAME_ABORT_I = 1'b0;
      repeat (3) @(negedge REF_CLK_I);
      for (k = 0; k < 100 && LINE_VALID_O !== 1'b0; k++) @(negedge REF_CLK_I);
   endtask

   task automatic check_frame(input logic [15:0] len, input logic bad);
      int nw, i, n;
      logic [255:0] d;
      logic [31:0] ek;
      logic [7:0] base;
      logic lst;
      nw = (len + 31) / 32;
      cmp("word count", nw, q_data.size());
      for (i = 0; i < nw && q_data.size() > 0; i++) begin
         d = q_data.pop_front();
         lst = (i == nw - 1);
         ek = ets_pkg::KEEP_ALL;
         if (lst) for (n = len - 32 * i; n < 32; n++) ek[n] = 1'b0;
         if (i == 0) base = d[7:0];
         cmp("line keep", ek, q_keep.pop_front());
         cmp("line flags", {lst, bad && lst, 1'b0, bad && lst}, q_flag.pop_front());
         for (n = 0; n < 32; n++) begin
            if (ek[n]) begin
               cmp("line byte", (bad && lst) ? ets_pkg::ERR_CTRL_CODE : 8'(base + 32 * i + n), d[8*n +: 8]);
            end
         end
      end
      cmp("busy after frame", 1'b0, BUSY_O);
      $display("test frame of %0d bytes done", len);
   endtask

   task automatic end_of_test();
      $display("checks_done %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (3) @(negedge REF_CLK_I);
      NRST_I = 1'b1;
      repeat (3) @(negedge REF_CLK_I);
      TX_RESET_I = 1'b0;
      RX_RESET_I = 1'b0;
      repeat (6) @(negedge REF_CLK_I);
      cmp("ready after reset", 1'b1, ets_axis_if_inst.tready);
      cmp("sync resets low", 2'b00, {TX_RESET_SYNC_O, RX_RESET_SYNC_O});
      for (int j = 0; j < 6; j++) begin
         run_frame(lens[j], j % 2, 0, 0);
         check_frame(lens[j], j % 2);
      end
      run_frame(16'h0190, 1'b0, 0, 30);
      cmp("stall seen", 1'b1, stalls > 0);
      check_frame(16'h0190, 1'b0);
      @(negedge REF_CLK_I);
      TX_RESET_I = 1'b1;
      RX_RESET_I = 1'b1;
      repeat (3) @(negedge REF_CLK_I);
      cmp("sync resets high", 3'b110, {TX_RESET_SYNC_O, RX_RESET_SYNC_O, ets_axis_if_inst.tready});
      $display("test tx reset done");
      TX_RESET_I = 1'b0;
      RX_RESET_I = 1'b0;
      repeat (6) @(negedge REF_CLK_I);
      run_frame(16'h0028, 1'b0, 0, 0);
      check_frame(16'h0028, 1'b0);
      cmp("done pulses", 8, dones);
      run_frame(16'h00C8, 1'b0, 3, 0);
      cmp("underrun pulses", 1, underruns);
      cmp("abort entry", 36'h0_0000_0000 | 4'hF, {q_keep[$], q_flag[$]});
      $display("test abort done");
      end_of_test();
   end
endmodule
`default_nettype wire
